//--- src/hmw_pkg.sv
// Shared constants for the host memory window, interrupt source/mask and
// owner tag registers. Assumes byte-wide host register accesses.
package hmw_pkg;

   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int ADDR_W = 4;
   localparam int MEM_AW = 14;

   // ----------------------------------------
   // Host byte offsets
   // ----------------------------------------
   localparam logic [3:0] OFS_E2H_MBOX = 4'h1;
   localparam logic [3:0] OFS_PTR_LO = 4'h2;
   localparam logic [3:0] OFS_PTR_HI = 4'h3;
   localparam logic [3:0] OFS_WIN_B0 = 4'h4;
   localparam logic [3:0] OFS_WIN_B1 = 4'h5;
   localparam logic [3:0] OFS_WIN_B2 = 4'h6;
   localparam logic [3:0] OFS_WIN_B3 = 4'h7;
   localparam logic [3:0] OFS_SRC_LO = 4'h8;
   localparam logic [3:0] OFS_SRC_HI = 4'h9;
   localparam logic [3:0] OFS_MSK_LO = 4'hA;
   localparam logic [3:0] OFS_MSK_HI = 4'hB;
   localparam logic [3:0] OFS_OWNER = 4'hC;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int PTR_ATYPE_LSB = 0;
   localparam int PTR_DW_LSB = 2;
   localparam int PTR_DW_MSB = 14;
   localparam int PTR_SEG_BIT = 15;
   localparam int SRC_MBOX_BIT = 0;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [15:0] PTR_RST = 16'h0000;
   localparam logic [31:0] WIN_RST = 32'h0000_0000;
   localparam logic [15:0] SRC_RST = 16'h0000;
   localparam logic [15:0] MSK_RST = 16'h0000;
   localparam logic [7:0] OWNER_RST = 8'h00;
   localparam logic [7:0] RDATA_RST = 8'h00;

   // ----------------------------------------
   // Window access types (pointer bits 1:0)
   // ----------------------------------------
   typedef enum logic [1:0] {
      HMW_ACC_8 = 2'b00,
      HMW_ACC_16 = 2'b01,
      HMW_ACC_32 = 2'b10,
      HMW_ACC_AUTO = 2'b11
   } hmw_acc_t;

endpackage

//--- src/hmw_window_regs.sv
// Host side of the embedded memory window: pointer, 32-bit data window onto
// the controller data memory, interrupt source/mask pair and owner tag.
// Assumes the memory answers reads combinationally in the same cycle and
// that the protection inputs describe the dword the pointer selects.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Segment bit plus dword pointer bits form every window memory address.
// - Four byte lanes at 04h-07h expose a 32-bit window of memory data.
// - Writes in read-only or no-access regions update window but not memory.
// - Reads in no-access regions skip memory and keep window unchanged.
// - Auto-increment: byte 3 read advances out of bounds; byte 3 write does not.
// - Firmware writing the controller-to-host mailbox sets the mailbox flag.
// - Mailbox flag goes out unmasked as the raw mailbox event.
// - Masked event asserts when mailbox flag and its enable are both one.
// - Host reading the controller-to-host mailbox clears the mailbox flag.
// - Software interrupt bits clear on written one; zero leaves them alone.
// - Firmware may block host clearing of software interrupt bits.
// - Masked event asserts for any set software bit with its enable set.
// - Mask bit 0 gates the mailbox flag into the masked event.
// - Mask bits 15:1 gate software interrupt bits at the same position.
// - Owner tag at zero accepts any written value.
// - Owner tag non-zero: writing the same value clears it to zero.
// - Owner tag non-zero: writing a different value is ignored.
// - 32-bit mode: byte 0 read loads dword, byte 3 write stores dword.
// - Auto-increment mode: byte 3 access also advances the dword pointer.
// - 16-bit mode: byte 0/2 reads load, byte 1/3 writes store a halfword.
// - 8-bit mode: each lane read loads, each lane write stores that byte.
module hmw_window_regs
   import hmw_pkg::*;
(
   // Clock and resets
   input wire logic clk,
   input wire logic rst_n,
   input wire logic stby_rst_n,
   // Host register port
   input wire logic [hmw_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Controller data memory and its protection view
   output logic mem_re,
   output logic mem_we,
   output logic [3:0] mem_be,
   output logic [hmw_pkg::MEM_AW-1:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_read_only,
   input wire logic mem_no_access,
   // Firmware side of the mailbox and software interrupts
   input wire logic [7:0] e2h_mbox_data,
   input wire logic ec_mbox_written,
   input wire logic [15:1] sw_interrupt_bits_set,
   input wire logic sw_interrupt_bits_clear_disable,
   // Event lines toward the runtime register block
   output logic raw_mailbox_event,
   output logic masked_interrupt_event
);
   import hmw_pkg::*;

   // ----------------------------------------
   // Lane masks
   // ----------------------------------------
   // One-hot byte enable for a single host lane
   function automatic logic [3:0] lane_onehot(input logic [1:0] lane);
      logic [3:0] m;
      m = 4'h0;
      unique case (lane)
         2'd0: m = 4'h1;
         2'd1: m = 4'h2;
         2'd2: m = 4'h4;
         2'd3: m = 4'h8;
      endcase
      return m;
   endfunction

   // Byte lanes a host read pulls from memory
   function automatic logic [3:0] load_mask(input hmw_acc_t acc, input logic [1:0] lane);
      logic [3:0] m;
      m = 4'h0;
      unique case (acc)
         HMW_ACC_8: m = lane_onehot(lane);
         HMW_ACC_16: begin
            if (lane == 2'd0) begin
               m = 4'h3;
            end else if (lane == 2'd2) begin
               m = 4'hC;
            end
         end
         HMW_ACC_32, HMW_ACC_AUTO: begin
            if (lane == 2'd0) begin
               m = 4'hF;
            end
         end
      endcase
      return m;
   endfunction

   // Byte lanes a host write pushes to memory
   function automatic logic [3:0] store_mask(input hmw_acc_t acc, input logic [1:0] lane);
      logic [3:0] m;
      m = 4'h0;
      unique case (acc)
         HMW_ACC_8: m = lane_onehot(lane);
         HMW_ACC_16: begin
            if (lane == 2'd1) begin
               m = 4'h3;
            end else if (lane == 2'd3) begin
               m = 4'hC;
            end
         end
         HMW_ACC_32, HMW_ACC_AUTO: begin
            if (lane == 2'd3) begin
               m = 4'hF;
            end
         end
      endcase
      return m;
   endfunction

   // Replace one byte of a 16-bit register
   function automatic logic [15:0] put_byte(input logic [15:0] v, input logic hi, input logic [7:0] b);
      logic [15:0] r;
      r = v;
      if (hi) begin
         r[15:8] = b;
      end else begin
         r[7:0] = b;
      end
      return r;
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   // Each register pairs with the value it takes at the next edge
   logic [15:0] ptr_reg;
   logic [15:0] ptr_next;
   logic [31:0] win_reg;
   logic [31:0] win_next;
   logic [15:0] src_reg;
   logic [15:0] src_next;
   logic [15:0] msk_reg;
   logic [15:0] msk_next;
   logic [7:0] own_reg;
   logic [7:0] own_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   wire hmw_acc_t acc = hmw_acc_t'(ptr_reg[PTR_ATYPE_LSB +: 2]);
   wire logic [1:0] lane = reg_addr[1:0];
   // Offsets 04h-07h form the four window lanes
   wire logic hit_win = (reg_addr >= OFS_WIN_B0) && (reg_addr <= OFS_WIN_B3);
   wire logic rd_win = reg_rd && hit_win;
   wire logic wr_win = reg_wr && hit_win;
   wire logic wr_ptr_lo = reg_wr && (reg_addr == OFS_PTR_LO);
   wire logic wr_ptr_hi = reg_wr && (reg_addr == OFS_PTR_HI);
   wire logic wr_src_lo = reg_wr && (reg_addr == OFS_SRC_LO);
   wire logic wr_src_hi = reg_wr && (reg_addr == OFS_SRC_HI);
   wire logic wr_msk_lo = reg_wr && (reg_addr == OFS_MSK_LO);
   wire logic wr_msk_hi = reg_wr && (reg_addr == OFS_MSK_HI);
   wire logic wr_owner = reg_wr && (reg_addr == OFS_OWNER);
   wire logic rd_mbox = reg_rd && (reg_addr == OFS_E2H_MBOX);
   wire logic wr_ptr = wr_ptr_lo || wr_ptr_hi;
   wire logic wr_msk = wr_msk_lo || wr_msk_hi;

   // ----------------------------------------
   // Pointer fields
   // ----------------------------------------
   wire logic ptr_seg = ptr_reg[PTR_SEG_BIT];
   wire logic [12:0] ptr_dword = ptr_reg[PTR_DW_MSB:PTR_DW_LSB];
   wire logic lane_last = lane == 2'd3;
   wire logic mode_auto = acc == HMW_ACC_AUTO;
   wire logic [3:0] ld_lanes = load_mask(acc, lane);
   wire logic [3:0] st_lanes = store_mask(acc, lane);

   // ----------------------------------------
   // Memory transfers
   // ----------------------------------------
   // No-access blocks the load outright; the window keeps its bytes
   wire logic [3:0] rd_be = rd_win && !mem_no_access ? ld_lanes : 4'h0;
   wire logic [3:0] wr_be = wr_win ? st_lanes : 4'h0;
   // Read-only and no-access both refuse stores; only no-access refuses loads
   wire logic wr_blocked = mem_read_only || mem_no_access;

   assign mem_addr = {ptr_seg, ptr_dword};
   assign mem_re = |rd_be;
   assign mem_we = (|wr_be) && !wr_blocked;
   // Strobes never coincide, so one enable bus serves both directions
   assign mem_be = mem_we ? wr_be : rd_be;
   // Store carries the byte being written in this same cycle
   assign mem_wdata = win_next;

   // ----------------------------------------
   // Window register
   // ----------------------------------------
   // Loads land first, then the host byte overlays its own lane
   always_comb begin
      win_next = win_reg;
      for (int i = 0; i < 4; i++) begin
         if (rd_be[i]) begin
            win_next[8*i +: 8] = mem_rdata[8*i +: 8];
         end
      end
      if (wr_win) begin
         win_next[8*lane +: 8] = reg_wdata;
      end
   end

   always_ff @(posedge clk) begin
      // System reset leaves the window alone; only standby power-on clears it
      if (!stby_rst_n) begin
         win_reg <= WIN_RST;
      end else begin
         win_reg <= win_next;
      end
   end

   // ----------------------------------------
   // Pointer
   // ----------------------------------------
   // Writes into no-access regions do not step; read-only writes and all reads step
   wire logic step_ptr = mode_auto && lane_last
      && (rd_win || (wr_win && !mem_no_access));
   wire logic [12:0] dw_inc = ptr_dword + 13'd1;

   always_comb begin
      ptr_next = ptr_reg;
      // A host write to the pointer takes priority over the auto step
      if (wr_ptr) begin
         ptr_next = put_byte(ptr_reg, wr_ptr_hi, reg_wdata);
      end else if (step_ptr) begin
         // Wraps inside the segment; the segment bit is left alone
         ptr_next[PTR_DW_MSB:PTR_DW_LSB] = dw_inc;
      end
   end

   always_ff @(posedge clk) begin
      // Only system reset clears the pointer; standby reset keeps it
      if (!rst_n) begin
         ptr_reg <= PTR_RST;
      end else begin
         ptr_reg <= ptr_next;
      end
   end

   // ----------------------------------------
   // Interrupt source and mask
   // ----------------------------------------
   // Host write-one-to-clear for software bits; bit 0 is read-only
   wire logic [15:0] swi_clr_raw = wr_src_lo ? {8'h00, reg_wdata}
      : (wr_src_hi ? {reg_wdata, 8'h00} : 16'h0000);
   wire logic swi_gate_open = !sw_interrupt_bits_clear_disable;
   wire logic [15:1] swi_clr = swi_gate_open ? swi_clr_raw[15:1] : 15'h0000;
   wire logic [15:1] swi_kept = src_reg[15:1] & ~swi_clr;

   always_comb begin
      src_next = src_reg;
      // A set in the same cycle as a clear wins
      src_next[15:1] = swi_kept | sw_interrupt_bits_set;
      // Mailbox bit: firmware sets it, a host read of the mailbox clears it
      if (ec_mbox_written) begin
         src_next[SRC_MBOX_BIT] = 1'b1;
      end else if (rd_mbox) begin
         src_next[SRC_MBOX_BIT] = 1'b0;
      end
   end

   always_comb begin
      msk_next = msk_reg;
      if (wr_msk) begin
         msk_next = put_byte(msk_reg, wr_msk_hi, reg_wdata);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         src_reg <= SRC_RST;
      end else begin
         src_reg <= src_next;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         msk_reg <= MSK_RST;
      end else begin
         msk_reg <= msk_next;
      end
   end

   // ----------------------------------------
   // Event outputs
   // ----------------------------------------
   // Both events are decoded from registers, so they change only on a clock edge
   wire logic mbox_pending = src_reg[SRC_MBOX_BIT] && msk_reg[SRC_MBOX_BIT];
   wire logic swi_pending = |(src_reg[15:1] & msk_reg[15:1]);
   assign raw_mailbox_event = src_reg[SRC_MBOX_BIT];
   assign masked_interrupt_event = mbox_pending || swi_pending;

   // ----------------------------------------
   // Owner tag semaphore
   // ----------------------------------------
   // Zero means unclaimed; only the holder's own tag releases a claim
   wire logic own_free = own_reg == OWNER_RST;
   wire logic own_match = reg_wdata == own_reg;

   always_comb begin
      own_next = own_reg;
      if (wr_owner) begin
         if (own_free) begin
            own_next = reg_wdata;
         end else if (own_match) begin
            own_next = OWNER_RST;
         end
         // Any other value leaves the claim standing
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         own_reg <= OWNER_RST;
      end else begin
         own_reg <= own_next;
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   // Window reads return the freshly loaded byte, not the stale one
   wire logic [7:0] win_lane_byte = win_next[8*lane +: 8];

   always_comb begin
      rdata_next = 8'h00;
      unique case (reg_addr)
         OFS_E2H_MBOX: rdata_next = e2h_mbox_data;
         OFS_PTR_LO: rdata_next = ptr_reg[7:0];
         OFS_PTR_HI: rdata_next = ptr_reg[15:8];
         OFS_WIN_B0, OFS_WIN_B1, OFS_WIN_B2, OFS_WIN_B3: rdata_next = win_lane_byte;
         OFS_SRC_LO: rdata_next = src_reg[7:0];
         OFS_SRC_HI: rdata_next = src_reg[15:8];
         OFS_MSK_LO: rdata_next = msk_reg[7:0];
         OFS_MSK_HI: rdata_next = msk_reg[15:8];
         OFS_OWNER: rdata_next = own_reg;
         default: rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_reg <= RDATA_RST;
      end else begin
         if (reg_rd) begin
            rdata_reg <= rdata_next;
         end else begin
            // Read data stand for one cycle only
            rdata_reg <= RDATA_RST;
         end
      end
   end

   assign reg_rdata = rdata_reg;

endmodule

`default_nettype wire

//--- tb/hmw_window_regs_asserts.sv
// Checker for the host memory window block, bound to its ports.
// Assumes one clock and byte-wide host accesses.
`timescale 1ns/10ps
`default_nettype none
module hmw_window_regs_asserts
   import hmw_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [hmw_pkg::ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic mem_re,
   input wire logic mem_we,
   input wire logic [3:0] mem_be,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_read_only,
   input wire logic mem_no_access,
   input wire logic ec_mbox_written,
   input wire logic [15:1] sw_interrupt_bits_set,
   input wire logic raw_mailbox_event,
   input wire logic masked_interrupt_event
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   wire logic win = reg_addr[3:2] == 2'b01;
   wire logic cause = reg_wr | ec_mbox_written | (|sw_interrupt_bits_set);
   mbox_set_a:
   assert property (ec_mbox_written |=> raw_mailbox_event) else $error("mailbox flag not set");
   raw_cause_a:
   assert property ($rose(raw_mailbox_event) |-> $past(ec_mbox_written)) else $error("raw event without write");
   mbox_clr_a:
   assert property (reg_rd && reg_addr == OFS_E2H_MBOX && !ec_mbox_written |=> !raw_mailbox_event)
      else $error("mailbox flag not cleared");
   ro_write_a:
   assert property (reg_wr && (mem_read_only || mem_no_access) |-> !mem_we) else $error("protected store");
   na_read_a:
   assert property (reg_rd && mem_no_access |-> !mem_re) else $error("load from no-access region");
   memre_cause_a:
   assert property (mem_re |-> reg_rd && win) else $error("stray memory load");
   load_ret_a:
   assert property (reg_rd && reg_addr == OFS_WIN_B0 && mem_re && mem_be == 4'hF
      |=> reg_rdata == $past(mem_rdata[7:0])) else $error("loaded byte not returned");
   masked_cause_a:
   assert property ($rose(masked_interrupt_event) |-> $past(cause)) else $error("masked event without cause");
endmodule
bind hmw_window_regs hmw_window_regs_asserts hmw_window_regs_asserts_i (.clk, .rst_n, .reg_addr, .reg_wr,
   .reg_rd, .reg_rdata, .mem_re, .mem_we, .mem_be, .mem_rdata, .mem_read_only, .mem_no_access,
   .ec_mbox_written, .sw_interrupt_bits_set, .raw_mailbox_event, .masked_interrupt_event);
`default_nettype wire

//--- tb/hmw_mem_model.sv
// Controller data memory behind the window, with region protection.
// Dwords 16 and up are out of bounds, dword 15 is read-only.
`timescale 1ns/10ps
`default_nettype none
module hmw_mem_model
   import hmw_pkg::*;
(
   input wire logic clk,
   input wire logic mem_we,
   input wire logic [3:0] mem_be,
   input wire logic [hmw_pkg::MEM_AW-1:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   output logic [31:0] mem_rdata,
   output logic mem_read_only,
   output logic mem_no_access
);
   logic [31:0] mem_reg [0:31];
   wire logic [4:0] idx = {mem_addr[13], mem_addr[3:0]};
   assign mem_no_access = |mem_addr[12:4];
   assign mem_read_only = mem_addr[3:0] == 4'hF;
   // Inverted data out of bounds, so a stray load shows
   assign mem_rdata = mem_no_access ? ~mem_reg[idx] : mem_reg[idx];
   initial begin
      for (int i = 0; i < 32; i++) begin
         mem_reg[i] = 32'h0000_0000;
      end
   end
   always @(posedge clk) begin
      for (int b = 0; b < 4; b++) begin
         if (mem_we && mem_be[b]) begin
            mem_reg[idx][8*b +: 8] <= mem_wdata[8*b +: 8];
         end
      end
   end
endmodule
`default_nettype wire

//--- tb/hmw_window_regs_tb.sv
// Self-checking bench for the host memory window block.
// Uses the memory model beside it; the checker is bound to the design.
`timescale 1ns/10ps
`default_nettype none
module hmw_window_regs_tb;
   import hmw_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic stby_rst_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic ec_mbox_written = 1'b0;
   logic [15:1] sw_interrupt_bits_set = 15'h0000;
   logic sw_interrupt_bits_clear_disable = 1'b0;
   logic [7:0] reg_rdata;
   logic [3:0] mem_be;
   logic [13:0] mem_addr;
   logic [31:0] mem_wdata;
   logic [31:0] mem_rdata;
   logic mem_we, ro, na, raw, masked;
   int errors = 0;
   int check_count = 0;
   always #2 clk = ~clk;
   hmw_window_regs hmw_window_regs_i (.clk, .rst_n, .stby_rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .mem_re(), .mem_we, .mem_be, .mem_addr, .mem_wdata, .mem_rdata, .mem_read_only(ro),
      .mem_no_access(na), .e2h_mbox_data(8'h3C), .ec_mbox_written, .sw_interrupt_bits_set, .sw_interrupt_bits_clear_disable,
      .raw_mailbox_event(raw), .masked_interrupt_event(masked));
   hmw_mem_model hmw_mem_model_i (.clk, .mem_we, .mem_be, .mem_addr, .mem_wdata, .mem_rdata,
      .mem_read_only(ro), .mem_no_access(na));
   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (e !== g) begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk($sformatf("offset %h", a), e, reg_rdata);
   endtask
   task automatic ev(input logic [7:0] e);
      #1;
      chk("raw and masked events", e, {6'h00, raw, masked});
   endtask
   task automatic results;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      rd(4'h8, 8'h00);
      rd(4'hA, 8'h00);
      rd(4'hC, 8'h00);
      rd(4'h4, 8'h00);
      rd(4'hD, 8'h00);
   endtask
   task automatic t_win32;
      wr(4'h2, 8'h06);
      wr(4'h4, 8'h11);
      wr(4'h5, 8'h22);
      wr(4'h6, 8'h33);
      wr(4'h7, 8'h44);
      wr(4'h4, 8'hAA);
      rd(4'h5, 8'h22);
      rd(4'h4, 8'h11);
      rd(4'h7, 8'h44);
   endtask
   task automatic t_narrow;
      wr(4'h2, 8'h04);
      wr(4'h5, 8'h55);
      wr(4'h2, 8'h05);
      wr(4'h6, 8'h66);
      wr(4'h7, 8'h77);
      wr(4'h2, 8'h06);
      rd(4'h4, 8'h11);
      rd(4'h5, 8'h55);
      rd(4'h6, 8'h66);
      wr(4'h3, 8'h80);
      rd(4'h4, 8'h00);
      wr(4'h3, 8'h00);
      rd(4'h4, 8'h11);
   endtask
   task automatic t_auto;
      wr(4'h2, 8'h0B);
      wr(4'h4, 8'hA1);
      wr(4'h7, 8'hA4);
      rd(4'h2, 8'h0F);
      wr(4'h2, 8'h0B);
      rd(4'h4, 8'hA1);
      rd(4'h7, 8'hA4);
      rd(4'h2, 8'h0F);
   endtask
   task automatic t_prot;
      wr(4'h2, 8'h3E);
      wr(4'h7, 8'h99);
      rd(4'h7, 8'h99);
      rd(4'h4, 8'h00);
      rd(4'h7, 8'h00);
      wr(4'h2, 8'h42);
      wr(4'h4, 8'h5A);
      rd(4'h4, 8'h5A);
      wr(4'h2, 8'h43);
      wr(4'h7, 8'h01);
      rd(4'h2, 8'h43);
      rd(4'h7, 8'h01);
      rd(4'h2, 8'h47);
   endtask
   task automatic t_irq;
      @(posedge clk);
      ec_mbox_written <= 1'b1;
      @(posedge clk);
      ec_mbox_written <= 1'b0;
      ev(8'h02);
      rd(4'h8, 8'h01);
      wr(4'h8, 8'h01);
      wr(4'hA, 8'h01);
      ev(8'h03);
      rd(4'h1, 8'h3C);
      ev(8'h00);
      @(posedge clk);
      sw_interrupt_bits_set <= 15'h0004;
      sw_interrupt_bits_clear_disable <= 1'b1;
      @(posedge clk);
      sw_interrupt_bits_set <= 15'h0000;
      ev(8'h00);
      wr(4'hA, 8'h08);
      ev(8'h01);
      wr(4'h8, 8'h08);
      rd(4'h8, 8'h08);
      @(posedge clk);
      sw_interrupt_bits_clear_disable <= 1'b0;
      wr(4'h8, 8'h00);
      rd(4'h8, 8'h08);
      wr(4'h8, 8'h08);
      rd(4'h8, 8'h00);
      @(posedge clk);
      sw_interrupt_bits_set <= 15'h4000;
      @(posedge clk);
      sw_interrupt_bits_set <= 15'h0000;
      ev(8'h00);
      wr(4'hB, 8'h80);
      ev(8'h01);
      wr(4'h9, 8'h80);
      rd(4'h9, 8'h00);
   endtask
   task automatic t_owner;
      wr(4'hC, 8'h5A);
      rd(4'hC, 8'h5A);
      wr(4'hC, 8'h33);
      rd(4'hC, 8'h5A);
      wr(4'hC, 8'h5A);
      rd(4'hC, 8'h00);
   endtask
   task automatic t_stby;
      wr(4'h2, 8'h06);
      wr(4'h5, 8'h5A);
      rd(4'h5, 8'h5A);
      @(posedge clk);
      stby_rst_n <= 1'b0;
      @(posedge clk);
      stby_rst_n <= 1'b1;
      rd(4'h5, 8'h00);
      rd(4'h2, 8'h06);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      stby_rst_n <= 1'b1;
      t_reset();
      t_win32();
      t_narrow();
      t_auto();
      t_prot();
      t_irq();
      t_owner();
      t_stby();
      results();
   end
   // About thirty times the span the scenarios need
   initial begin
      #20000;
      errors++;
      results();
   end
endmodule
`default_nettype wire
